// ---- rtl/rps_pkg.sv ----
/*
  Constants and types shared by the slope protection stage:
  fixed-point scaling, settings defaults, event codes and record layout.
  Assumes slope samples in 0.001 Hz/s units and frequency in 0.01 Hz.
*/
package rps_pkg;
  // slope in 0.001 Hz/s, frequency in 0.01 Hz, both 16 bit
  localparam int RPS_SW = 16;
  localparam int RPS_FW = 16;
  localparam int RPS_TW = 32;
  localparam int RPS_CW = 16;
  localparam int RPS_GW = 3;
  localparam int RPS_NGRP = 8;
  localparam int RPS_DEPTH = 12;
  localparam int RPS_PW = 4;

  localparam logic [RPS_SW-1:0] RPS_HYST = 16'h0064;      // 100 mHz/s
  localparam logic [RPS_SW-1:0] RPS_PICKUP_DEF = 16'h00c8; // 0.2 Hz/s
  localparam logic [RPS_SW-1:0] RPS_STEP = 16'h000a;      // 0.01 Hz/s
  localparam logic [RPS_SW-1:0] RPS_MAXRATE_DEF = 16'h4e20; // 20 Hz/s
  localparam logic [RPS_FW-1:0] RPS_FLO_DEF = 16'h1383;   // 49.95 Hz
  localparam logic [RPS_FW-1:0] RPS_FHI_DEF = 16'h13ec;   // 51 Hz

  // ratio resolution 0.005 p.u. => ratio counted in units of 1/200
  localparam int RPS_RATIO_SCALE = 200;
  localparam int RPS_RW = 16;

  // program cycle 5 ms; 20 ms history => 4 samples back
  localparam int RPS_CYCLE_MS = 5;
  localparam int RPS_PRETRIG_MS = 20;
  localparam int RPS_PRE_N = RPS_PRETRIG_MS / RPS_CYCLE_MS;
  // remaining time resolution 0.005 s equals one cycle
  localparam int RPS_TIME_RES_MS = 5;

  typedef enum logic [1:0] {
    RPS_MODE_RISE,
    RPS_MODE_FALL,
    RPS_MODE_BOTH
  } rps_mode_e;

  typedef enum logic [1:0] {
    RPS_COND_NORMAL,
    RPS_COND_START,
    RPS_COND_TRIP,
    RPS_COND_BLOCKED
  } rps_cond_e;

  // event codes: kind in [2:1], on/off in [0]
  localparam logic [2:0] RPS_EV_START_ON = 3'h1;
  localparam logic [2:0] RPS_EV_START_OFF = 3'h0;
  localparam logic [2:0] RPS_EV_TRIP_ON = 3'h3;
  localparam logic [2:0] RPS_EV_TRIP_OFF = 3'h2;
  localparam logic [2:0] RPS_EV_BLK_ON = 3'h5;
  localparam logic [2:0] RPS_EV_BLK_OFF = 3'h4;

  // record: time, event, pre slope, pre freq, fault slope, fault freq, grp
  localparam int RPS_RECW = RPS_TW + 3 + 2 * RPS_SW + 2 * RPS_FW + RPS_GW;
endpackage

// ---- rtl/rps_counter3.sv ----
/*
  Three cumulative event counters for start, trip and blocked.
  Assumes one-cycle occurrence pulses from the same clock.
*/
`timescale 1ns/1ps
module rps_counter3
  import rps_pkg::*;
#(
  parameter int CW = RPS_CW
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_clear,
  input wire logic [2:0] i_inc,
  output logic [CW-1:0] o_cnt_start,
  output logic [CW-1:0] o_cnt_trip,
  output logic [CW-1:0] o_cnt_blk
);
  logic [CW-1:0] cnt_r [3];
  logic [CW-1:0] cnt_nxt [3];

  // an occurrence in the clear cycle counts as one, so it is not lost
  always_comb begin
    for (int k = 0; k < 3; k++) begin
      if (i_clear) begin
        cnt_nxt[k] = i_inc[k] ? CW'(1) : '0;
      end else begin
        cnt_nxt[k] = cnt_r[k] + CW'(i_inc[k]);
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      for (int k = 0; k < 3; k++) cnt_r[k] <= '0;
    end else begin
      for (int k = 0; k < 3; k++) cnt_r[k] <= cnt_nxt[k];
    end
  end

  assign o_cnt_start = cnt_r[0];
  assign o_cnt_trip = cnt_r[1];
  assign o_cnt_blk = cnt_r[2];

  AST_CNT_INC: assert property (
    @(posedge i_clk) disable iff (i_reset)
    !i_clear && i_inc[1] |=> cnt_r[1] == $past(cnt_r[1]) + CW'(1))
    else $error("trip counter did not step");
endmodule

// ---- rtl/rps_recstore.sv ----
/*
  Circular store of the newest operation records, oldest overwritten.
  Assumes a one-cycle write strobe with the record word alongside.
*/
`timescale 1ns/1ps
module rps_recstore
  import rps_pkg::*;
#(
  parameter int DEPTH = RPS_DEPTH,
  parameter int W = RPS_RECW
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_wr,
  input wire logic [W-1:0] i_rec,
  input wire logic [RPS_PW-1:0] i_rd_idx,
  output logic [W-1:0] o_rd_rec,
  output logic [RPS_PW-1:0] o_count,
  output logic [RPS_PW-1:0] o_wptr
);
  logic [W-1:0] mem_r [DEPTH];
  logic [RPS_PW-1:0] wptr_r, wptr_nxt, cnt_r, cnt_nxt;
  logic [W-1:0] rd_r, rd_nxt;

  // pointer wraps so the oldest slot is written next
  always_comb begin
    wptr_nxt = wptr_r;
    cnt_nxt = cnt_r;
    rd_nxt = (i_rd_idx < RPS_PW'(DEPTH)) ? mem_r[i_rd_idx] : '0;
    if (i_wr) begin
      wptr_nxt = (wptr_r == RPS_PW'(DEPTH - 1)) ? '0 : wptr_r + 1'b1;
      if (cnt_r != RPS_PW'(DEPTH)) cnt_nxt = cnt_r + 1'b1;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      wptr_r <= '0;
      cnt_r <= '0;
      rd_r <= '0;
    end else begin
      wptr_r <= wptr_nxt;
      cnt_r <= cnt_nxt;
      rd_r <= rd_nxt;
    end
  end

  // storage array has no reset; unwritten slots read unknown, reads are not gated by o_count
  always_ff @(posedge i_clk) begin
    if (i_wr) mem_r[wptr_r] <= i_rec;
  end

  assign o_rd_rec = rd_r;
  assign o_count = cnt_r;
  assign o_wptr = wptr_r;

  AST_REC_WRAP: assert property (
    @(posedge i_clk) disable iff (i_reset)
    i_wr && wptr_r == RPS_PW'(DEPTH - 1) |=> wptr_r == '0)
    else $error("record pointer failed to wrap");
endmodule

// ---- rtl/rps_stage.sv ----
/*
  Frequency slope protection stage: pick-up with hysteresis, direction
  and frequency limits, blocking, definite delay, events and records.
  Assumes i_cycle pulses once per program cycle with fresh samples, and
  settings from the setting-group logic held steady on the same clock.
*/
// Overview of operation
// - release after slope falls 100 mHz/s back
// - limits inhibit operation near nominal frequency
// - direction selects rising, falling or both
// - pick up when slope exceeds set magnitude
// - falling trips only below under limit; in both mode the code also trips a falling slope above over limit
// - rising trips only above over limit; in both mode the code also trips a rising slope below under limit
// - selector applies or ignores frequency limits
// - stage active only where group enables
// - group change applies without restart
// - operate delay is definite time only
// - block input sampled at cycle start
// - unblocked pick-up raises start, starts timing
// - blocked pick-up raises blocked, no timing
// - late block clears start, releases normally
// - time-stamped selectable on/off events
// - resettable start, trip, blocked counters
// - twelve record circular store
// - record holds pre-trig and fault values
// - live slope and per-unit ratio shown
// - remaining time countdown while timing
// - condition normal, start, trip or blocked
// - excessive slope blocks whole function
`timescale 1ns/1ps
module rps_stage
  import rps_pkg::*;
#(
  parameter int SW = RPS_SW,
  parameter int FW = RPS_FW,
  parameter int TW = RPS_TW,
  parameter int CW = RPS_CW
) (
  input wire logic I_CLK,
  input wire logic I_RESET,
  input wire logic i_CYCLE,
  input wire logic signed [SW-1:0] i_SLOPE,
  input wire logic [FW-1:0] i_FREQ,
  input wire logic i_BLOCK,
  input wire logic [TW-1:0] i_TIME,
  input wire logic [RPS_GW-1:0] i_GROUP,
  input wire logic [RPS_NGRP-1:0] i_GRP_ENABLE,
  input wire logic [1:0] i_MODE,
  input wire logic i_USE_FLIMIT,
  input wire logic [SW-1:0] i_PICKUP,
  input wire logic [FW-1:0] i_FLO,
  input wire logic [FW-1:0] i_FHI,
  input wire logic [SW-1:0] i_MAXRATE,
  input wire logic [CW-1:0] i_DELAY_CYC,
  input wire logic [5:0] i_EV_SEL,
  input wire logic i_CNT_CLEAR,
  input wire logic [RPS_PW-1:0] i_REC_IDX,
  output logic o_START,
  output logic o_TRIP,
  output logic o_BLOCKED,
  output logic [1:0] o_COND,
  output logic o_EV_VALID,
  output logic [2:0] o_EV_CODE,
  output logic [TW-1:0] o_EV_TIME,
  output logic [SW-1:0] o_MEAS_SLOPE,
  output logic [RPS_RW-1:0] o_RATIO,
  output logic [CW-1:0] o_REMAIN,
  output logic [CW-1:0] o_CNT_START,
  output logic [CW-1:0] o_CNT_TRIP,
  output logic [CW-1:0] o_CNT_BLK,
  output logic [RPS_RECW-1:0] o_REC,
  output logic [RPS_PW-1:0] o_REC_COUNT
);
  rps_cond_e st_r, st_nxt;
  logic blk_s1_r, blk_s2_r;
  logic [CW-1:0] tmr_r, tmr_nxt;
  logic picked_r, picked_nxt;
  logic [SW-1:0] hist_s_r [RPS_PRE_N];
  logic [FW-1:0] hist_f_r [RPS_PRE_N];
  logic ev_v_r, ev_v_nxt;
  logic [2:0] ev_c_r, ev_c_nxt;
  logic [TW-1:0] ev_t_r, ev_t_nxt;
  logic [SW-1:0] mag_r, mag_nxt;
  logic [RPS_RW-1:0] ratio_r, ratio_nxt;
  logic [2:0] inc;
  logic rec_wr;
  logic [RPS_RECW-1:0] rec_word;
  logic [SW-1:0] mag, rel_lvl;
  logic dir_ok, lim_ok, active, over_max, pick_now;
  logic [RPS_RW-1:0] ratio_calc;
  logic [2:0] ev_raw;

  function automatic logic [SW-1:0] abs_s(input logic signed [SW-1:0] v);
    abs_s = v[SW-1] ? SW'(-v) : SW'(v);
  endfunction

  // block pin is from the matrix domain: two flops before use
  always_ff @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      blk_s1_r <= 1'b0;
      blk_s2_r <= 1'b0;
    end else begin
      blk_s1_r <= i_BLOCK;
      blk_s2_r <= blk_s1_r;
    end
  end

  // qualification: magnitude, direction, limits, group enable, max rate
  always_comb begin
    mag = abs_s(i_SLOPE);
    rel_lvl = (i_PICKUP > RPS_HYST) ? i_PICKUP - RPS_HYST : '0;
    case (rps_mode_e'(i_MODE))
      RPS_MODE_FALL: dir_ok = i_SLOPE[SW-1];
      RPS_MODE_BOTH: dir_ok = 1'b1;
      default: dir_ok = !i_SLOPE[SW-1];
    endcase
    // limits only bite when selected; both mode needs either side
    if (!i_USE_FLIMIT) begin
      lim_ok = 1'b1;
    end else if (rps_mode_e'(i_MODE) == RPS_MODE_FALL) begin
      lim_ok = i_FREQ < i_FLO;
    end else if (rps_mode_e'(i_MODE) == RPS_MODE_BOTH) begin
      lim_ok = (i_FREQ < i_FLO) || (i_FREQ > i_FHI);
    end else begin
      lim_ok = i_FREQ > i_FHI;
    end
    // settings are read live each cycle, so a group switch takes hold
    active = i_GRP_ENABLE[i_GROUP];
    over_max = mag > i_MAXRATE;
    if (picked_r) begin
      pick_now = dir_ok && lim_ok && mag > rel_lvl;
    end else begin
      pick_now = dir_ok && lim_ok && mag > i_PICKUP;
    end
    pick_now = pick_now && active && !over_max;
    ratio_calc = (i_PICKUP == '0) ? '0 :
      RPS_RW'((32'(mag) * RPS_RATIO_SCALE) / 32'(i_PICKUP));
  end

  // state machine runs once per program cycle, block sampled first
  always_comb begin
    st_nxt = st_r;
    tmr_nxt = tmr_r;
    picked_nxt = picked_r;
    mag_nxt = mag_r;
    ratio_nxt = ratio_r;
    if (i_CYCLE) begin
      mag_nxt = mag;
      ratio_nxt = ratio_calc;
      picked_nxt = pick_now;
      case (st_r)
        RPS_COND_NORMAL: begin
          if (pick_now && blk_s2_r) begin
            st_nxt = RPS_COND_BLOCKED;
          end else if (pick_now) begin
            st_nxt = RPS_COND_START;
            tmr_nxt = i_DELAY_CYC;
          end
        end
        RPS_COND_START: begin
          if (!pick_now || blk_s2_r) begin
            st_nxt = RPS_COND_NORMAL;
            tmr_nxt = '0;
          end else if (tmr_r <= CW'(1)) begin
            st_nxt = RPS_COND_TRIP;
            tmr_nxt = '0;
          end else begin
            tmr_nxt = tmr_r - 1'b1;
          end
        end
        RPS_COND_TRIP: begin
          if (!pick_now) st_nxt = RPS_COND_NORMAL;
        end
        default: begin
          if (!pick_now) st_nxt = RPS_COND_NORMAL;
          else if (!blk_s2_r) st_nxt = RPS_COND_NORMAL;
        end
      endcase
    end
  end

  always_ff @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      st_r <= RPS_COND_NORMAL;
      tmr_r <= '0;
      picked_r <= 1'b0;
      mag_r <= '0;
      ratio_r <= '0;
    end else begin
      st_r <= st_nxt;
      tmr_r <= tmr_nxt;
      picked_r <= picked_nxt;
      mag_r <= mag_nxt;
      ratio_r <= ratio_nxt;
    end
  end

  // 20 ms history line shifted once per program cycle
  always_ff @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      for (int k = 0; k < RPS_PRE_N; k++) begin
        hist_s_r[k] <= '0;
        hist_f_r[k] <= '0;
      end
    end else if (i_CYCLE) begin
      hist_s_r[0] <= SW'(i_SLOPE);
      hist_f_r[0] <= i_FREQ;
      for (int k = 1; k < RPS_PRE_N; k++) begin
        hist_s_r[k] <= hist_s_r[k-1];
        hist_f_r[k] <= hist_f_r[k-1];
      end
    end
  end

  // status edges; entering start from blocked cannot happen directly
  always_comb begin
    ev_raw = '0;
    inc = '0;
    ev_v_nxt = 1'b0;
    ev_c_nxt = ev_c_r;
    ev_t_nxt = ev_t_r;
    if (st_nxt != st_r) begin
      if (st_nxt == RPS_COND_START) ev_raw = RPS_EV_START_ON;
      else if (st_nxt == RPS_COND_TRIP) ev_raw = RPS_EV_TRIP_ON;
      else if (st_nxt == RPS_COND_BLOCKED) ev_raw = RPS_EV_BLK_ON;
      else if (st_r == RPS_COND_START) ev_raw = RPS_EV_START_OFF;
      else if (st_r == RPS_COND_TRIP) ev_raw = RPS_EV_TRIP_OFF;
      else ev_raw = RPS_EV_BLK_OFF;
      inc[ev_raw[2:1]] = ev_raw[0];
      if (i_EV_SEL[ev_raw]) begin
        ev_v_nxt = 1'b1;
        ev_c_nxt = ev_raw;
        ev_t_nxt = i_TIME;
      end
    end
  end

  always_ff @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      ev_v_r <= 1'b0;
      ev_c_r <= '0;
      ev_t_r <= '0;
    end else begin
      ev_v_r <= ev_v_nxt;
      ev_c_r <= ev_c_nxt;
      ev_t_r <= ev_t_nxt;
    end
  end

  // a record is taken on each start or trip, with pre and fault values
  assign rec_wr = inc[0] | inc[1];
  assign rec_word = {i_TIME, ev_raw, hist_s_r[RPS_PRE_N-1],
    hist_f_r[RPS_PRE_N-1], SW'(i_SLOPE), i_FREQ, i_GROUP};

  rps_counter3 #(.CW(CW)) rps_counter3_inst (
    .i_clk(I_CLK),
    .i_reset(I_RESET),
    .i_clear(i_CNT_CLEAR),
    .i_inc(inc),
    .o_cnt_start(o_CNT_START),
    .o_cnt_trip(o_CNT_TRIP),
    .o_cnt_blk(o_CNT_BLK)
  );

  rps_recstore rps_recstore_inst (
    .i_clk(I_CLK),
    .i_reset(I_RESET),
    .i_wr(rec_wr),
    .i_rec(rec_word),
    .i_rd_idx(i_REC_IDX),
    .o_rd_rec(o_REC),
    .o_count(o_REC_COUNT),
    .o_wptr()
  );

  // outputs straight from state flops
  assign o_START = st_r == RPS_COND_START;
  assign o_TRIP = st_r == RPS_COND_TRIP;
  assign o_BLOCKED = st_r == RPS_COND_BLOCKED;
  assign o_COND = st_r;
  assign o_EV_VALID = ev_v_r;
  assign o_EV_CODE = ev_c_r;
  assign o_EV_TIME = ev_t_r;
  assign o_MEAS_SLOPE = mag_r;
  assign o_RATIO = ratio_r;
  assign o_REMAIN = tmr_r;

  AST_BLK_NO_START: assert property (
    @(posedge I_CLK) disable iff (I_RESET)
    st_r == RPS_COND_NORMAL && i_CYCLE && blk_s2_r |=> !o_START)
    else $error("start raised while blocked");
  AST_LATE_BLOCK: assert property (
    @(posedge I_CLK) disable iff (I_RESET)
    o_START && i_CYCLE && blk_s2_r |=> st_r == RPS_COND_NORMAL)
    else $error("late block did not clear start");
  AST_START_LOAD: assert property (
    @(posedge I_CLK) disable iff (I_RESET)
    $rose(o_START) |-> tmr_r == $past(i_DELAY_CYC))
    else $error("timer not loaded at start");
  AST_TRIP_FROM_START: assert property (
    @(posedge I_CLK) disable iff (I_RESET)
    $rose(o_TRIP) |-> $past(o_START) && $past(tmr_r) <= CW'(1))
    else $error("trip before delay expired");
  AST_MAXRATE: assert property (
    @(posedge I_CLK) disable iff (I_RESET)
    i_CYCLE && over_max |=> !o_START && !o_TRIP && !o_BLOCKED)
    else $error("active above max rate");
  AST_GROUP_OFF: assert property (
    @(posedge I_CLK) disable iff (I_RESET)
    i_CYCLE && !active |=> st_r == RPS_COND_NORMAL)
    else $error("stage active in disabled group");
  AST_COUNTDOWN: assert property (
    @(posedge I_CLK) disable iff (I_RESET)
    o_START && i_CYCLE && pick_now && !blk_s2_r && tmr_r > CW'(1)
    |=> tmr_r == $past(tmr_r) - CW'(1))
    else $error("countdown did not step");
  // judge at the transition: a deselected event leaves the old code up
  AST_EVENT_TIME: assert property (
    @(posedge I_CLK) disable iff (I_RESET)
    st_nxt != st_r && i_EV_SEL[ev_raw] |=> o_EV_VALID
    && o_EV_CODE == $past(ev_raw) && o_EV_TIME == $past(i_TIME))
    else $error("selected event missing");
  AST_HYST: assert property (
    @(posedge I_CLK) disable iff (I_RESET)
    o_START && i_CYCLE && dir_ok && lim_ok && active && !over_max
    && !blk_s2_r && mag > rel_lvl |=> o_START || o_TRIP)
    else $error("released inside hysteresis");
  COV_TRIP: cover property (@(posedge I_CLK) $rose(o_TRIP));
  COV_BLOCKED: cover property (@(posedge I_CLK) $rose(o_BLOCKED));
  COV_LATE_BLK: cover property (@(posedge I_CLK)
    o_START && i_CYCLE && blk_s2_r);
endmodule

// ---- testbench/rps_front_model.sv ----
/*
  Behavioural model of the frequency tracking front end and the blocking
  matrix. Assumes the bench sets the wanted slope, frequency and block level.
*/
`timescale 1ns/1ps
module rps_front_model #(
  parameter int PER = 8
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic signed [15:0] i_slope_set,
  input wire logic [15:0] i_freq_set,
  input wire logic i_blk_set,
  output logic o_cycle,
  output logic signed [15:0] o_slope,
  output logic [15:0] o_freq,
  output logic o_block,
  output logic [31:0] o_time
);
  int cnt;

  // the 5 ms program cycle shrinks to PER clocks to keep the run short
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      cnt <= 0;
      o_cycle <= 1'b0;
      o_slope <= 16'sh0000;
      o_freq <= 16'h0000;
      o_time <= 32'h0000_0000;
    end else begin
      o_time <= o_time + 32'h0000_0001;
      cnt <= (cnt == PER - 1) ? 0 : cnt + 1;
      o_cycle <= (cnt == PER - 1);
      // fresh samples travel with the pulse, as the tracker delivers them
      if (cnt == PER - 1) begin
        o_slope <= i_slope_set;
        o_freq <= i_freq_set;
      end
    end
  end

  // bench raises the block line most of a cycle ahead of the pulse
  assign o_block = i_blk_set;
endmodule

// ---- testbench/rps_stage_test.sv ----
/*
  Self-checking bench for the slope protection stage.
  Assumes the front-end model pulses a shortened program cycle.
*/
`timescale 1ns/1ps
module rps_stage_test import rps_pkg::*;;
  logic clk, rst, cyc, blk, blk_set, useflim, clr;
  logic signed [15:0] slope, slope_set;
  logic [15:0] freq, freq_set, pickup, flo, fhi, maxrate, delay;
  logic [31:0] tim, evt;
  logic [2:0] grp, evc;
  logic [7:0] gen;
  logic [1:0] mode, cond;
  logic [5:0] evsel;
  logic [3:0] recidx, rcnt;
  logic start, trip, blocked, evv;
  logic [15:0] meas, ratio, remain, cst, ctr, cbk;
  logic [RPS_RECW-1:0] rec;
  int err_total, cmp_count;
  int ev_cnt;

  rps_front_model rps_front_model_inst (.i_clk(clk), .i_reset(rst),
    .i_slope_set(slope_set), .i_freq_set(freq_set), .i_blk_set(blk_set),
    .o_cycle(cyc), .o_slope(slope), .o_freq(freq), .o_block(blk),
    .o_time(tim));

  rps_stage rps_stage_inst (.I_CLK(clk), .I_RESET(rst), .i_CYCLE(cyc),
    .i_SLOPE(slope), .i_FREQ(freq), .i_BLOCK(blk), .i_TIME(tim),
    .i_GROUP(grp), .i_GRP_ENABLE(gen), .i_MODE(mode),
    .i_USE_FLIMIT(useflim), .i_PICKUP(pickup), .i_FLO(flo), .i_FHI(fhi),
    .i_MAXRATE(maxrate), .i_DELAY_CYC(delay), .i_EV_SEL(evsel),
    .i_CNT_CLEAR(clr), .i_REC_IDX(recidx), .o_START(start),
    .o_TRIP(trip), .o_BLOCKED(blocked), .o_COND(cond), .o_EV_VALID(evv),
    .o_EV_CODE(evc), .o_EV_TIME(evt), .o_MEAS_SLOPE(meas),
    .o_RATIO(ratio), .o_REMAIN(remain), .o_CNT_START(cst),
    .o_CNT_TRIP(ctr), .o_CNT_BLK(cbk), .o_REC(rec), .o_REC_COUNT(rcnt));

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // event valid stands one clock only; count pulses for later checks
  always @(posedge clk) begin
    if (rst) begin
      ev_cnt <= 0;
    end else if (evv === 1'b1) begin
      ev_cnt <= ev_cnt + 1;
    end
  end

  task automatic report_and_stop();
    $display("Compares %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // new samples land just after an edge, well clear of the next pulse
  task automatic drive(input logic signed [15:0] s, input logic [15:0] f,
                       input logic b);
    @(posedge clk);
    slope_set <= s;
    freq_set <= f;
    blk_set <= b;
  endtask

  // let n pulses be evaluated, then sit where the answer has settled
  task automatic step(input int n);
    int k;
    for (int i = 0; i < n; i++) begin
      k = 0;
      do begin
        @(negedge clk);
        k++;
      end while (cyc !== 1'b1 && k < 40);
      if (k >= 40) begin
        err_total++;
        report_and_stop();
      end
    end
    @(posedge clk);
    @(posedge clk);
    #1;
  endtask

  task automatic t_enable();
    chk(cond, RPS_COND_NORMAL);
    chk(cst, 16'h0000);
    drive(16'sd500, 16'd5000, 1'b0);
    step(4);
    chk(start, 1'b0);
    drive(16'sd200, 16'd5000, 1'b0);
    gen <= 8'h04;
    step(1);
    chk(start, 1'b0);
    $display("test enable done");
  endtask

  task automatic t_pickup();
    int e0;
    e0 = ev_cnt;
    drive(16'sd201, 16'd5000, 1'b0);
    step(1);
    chk(start, 1'b1);
    chk(cond, RPS_COND_START);
    chk(remain, 16'd3);
    chk(ev_cnt, e0 + 1);
    // the stamp is the time seen at the evaluating edge, two clocks back
    chk(evt, tim - 32'd2);
    chk(rec[101:70], tim - 32'd2);
    chk(rec[66:51], 16'd500);
    chk(evc, RPS_EV_START_ON);
    chk(cst, 16'd1);
    chk(meas, 16'd201);
    chk(rec[69:67], RPS_EV_START_ON);
    chk(rec[50:35], 16'd5000);
    chk(rec[34:19], 16'd201);
    chk(rec[18:0], {16'd5000, 3'd2});
    step(2);
    chk(remain, 16'd1);
    chk(trip, 1'b0);
    step(1);
    chk(trip, 1'b1);
    chk(cond, RPS_COND_TRIP);
    chk(evc, RPS_EV_TRIP_ON);
    chk(ctr, 16'd1);
    drive(16'sd101, 16'd5000, 1'b0);
    step(1);
    chk(trip, 1'b1);
    drive(16'sd100, 16'd5000, 1'b0);
    step(1);
    chk(trip, 1'b0);
    chk(cond, RPS_COND_NORMAL);
    $display("test pickup done");
  endtask

  task automatic dcase(input logic [1:0] m, input logic u,
                       input logic [15:0] f, input logic signed [15:0] s,
                       input logic e);
    drive(s, f, 1'b0);
    mode <= m;
    useflim <= u;
    step(1);
    chk(start, e);
    drive(16'sd0, f, 1'b0);
    step(1);
  endtask

  task automatic t_dir();
    dcase(RPS_MODE_RISE, 1'b0, 16'd5000, 16'sd500, 1'b1);
    dcase(RPS_MODE_RISE, 1'b0, 16'd5000, -16'sd500, 1'b0);
    dcase(RPS_MODE_FALL, 1'b0, 16'd5000, -16'sd500, 1'b1);
    dcase(RPS_MODE_FALL, 1'b0, 16'd5000, 16'sd500, 1'b0);
    dcase(RPS_MODE_BOTH, 1'b0, 16'd5000, 16'sd500, 1'b1);
    dcase(RPS_MODE_BOTH, 1'b0, 16'd5000, -16'sd500, 1'b1);
    dcase(RPS_MODE_RISE, 1'b1, 16'd5000, 16'sd500, 1'b0);
    dcase(RPS_MODE_RISE, 1'b1, 16'd5101, 16'sd500, 1'b1);
    dcase(RPS_MODE_FALL, 1'b1, 16'd4994, -16'sd500, 1'b1);
    dcase(RPS_MODE_FALL, 1'b1, 16'd5000, -16'sd500, 1'b0);
    dcase(RPS_MODE_BOTH, 1'b1, 16'd5000, -16'sd500, 1'b0);
    dcase(RPS_MODE_FALL, 1'b0, 16'd5000, -16'sd500, 1'b1);
    dcase(RPS_MODE_RISE, 1'b0, 16'd4994, 16'sd500, 1'b1);
    $display("test direction done");
  endtask

  task automatic t_block();
    drive(16'sd500, 16'd5000, 1'b1);
    step(1);
    chk(blocked, 1'b1);
    chk(cond, RPS_COND_BLOCKED);
    chk(start, 1'b0);
    chk(evc, RPS_EV_BLK_ON);
    chk(cbk, 16'd1);
    step(4);
    chk(trip, 1'b0);
    drive(16'sd0, 16'd5000, 1'b0);
    step(1);
    drive(16'sd500, 16'd5000, 1'b0);
    step(1);
    chk(start, 1'b1);
    drive(16'sd500, 16'd5000, 1'b1);
    step(1);
    chk(start, 1'b0);
    step(3);
    chk(trip, 1'b0);
    drive(16'sd25000, 16'd5000, 1'b0);
    step(2);
    chk(start, 1'b0);
    $display("test block done");
  endtask

  task automatic t_group();
    drive(16'sd300, 16'd5000, 1'b0);
    step(1);
    chk(start, 1'b1);
    chk(ratio, 16'd300);
    drive(16'sd300, 16'd5000, 1'b0);
    pickup <= 16'd400;
    step(1);
    chk(start, 1'b0);
    drive(16'sd300, 16'd5000, 1'b0);
    pickup <= 16'd200;
    step(1);
    chk(start, 1'b1);
    drive(16'sd300, 16'd5000, 1'b0);
    grp <= 3'd1;
    step(1);
    chk(start, 1'b0);
    drive(16'sd0, 16'd5000, 1'b0);
    grp <= 3'd2;
    step(1);
    $display("test group done");
  endtask

  task automatic t_count();
    int e0;
    drive(16'sd0, 16'd5000, 1'b0);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    #1;
    chk(cst, 16'h0000);
    chk(cbk, 16'h0000);
    drive(16'sd500, 16'd5000, 1'b0);
    evsel <= 6'h3d;
    e0 = ev_cnt;
    step(1);
    chk(start, 1'b1);
    chk(ev_cnt, e0);
    chk(cst, 16'd1);
    // many start/release pairs to wrap the twelve-entry store
    for (int i = 0; i < 13; i++) begin
      drive(16'sd0, 16'd5000, 1'b0);
      step(1);
      drive(16'sd500, 16'd5000, 1'b0);
      step(1);
    end
    chk(rcnt, 4'd12);
    // a slot past the twelfth reads as zero
    @(posedge clk);
    recidx <= 4'hc;
    repeat (2) @(posedge clk);
    #1;
    chk(rec[31:0], 32'h0000_0000);
    $display("test counters done");
  endtask

  // settings at their defaults, stage disabled until the first test
  initial begin
    err_total = 0;
    cmp_count = 0;
    rst = 1'b1;
    slope_set = 16'sh0000;
    freq_set = 16'd5000;
    blk_set = 1'b0;
    grp = 3'd2;
    gen = 8'h00;
    mode = RPS_MODE_RISE;
    useflim = 1'b0;
    pickup = RPS_PICKUP_DEF;
    flo = RPS_FLO_DEF;
    fhi = RPS_FHI_DEF;
    maxrate = RPS_MAXRATE_DEF;
    delay = 16'd3;
    evsel = 6'h3f;
    clr = 1'b0;
    recidx = 4'h0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    t_enable();
    t_pickup();
    t_dir();
    t_block();
    t_group();
    t_count();
    report_and_stop();
  end
endmodule
